// [design/codec_antipop_tieoff_irq_regs.sv]
// Register bank for codec pop suppression, output tie-off and codec interrupts.
// Assumes a host register port of one-cycle read and write strobes, and
// detector and enable inputs already synchronous to mclk.
`timescale 1ns/1ps
// What this block does
// - Bits 9:8 pick reference ramp speed: none, fast, medium, slow; reset 00.
// - Bits 7:6 set fourth mono output discharge rate or off; reset 00.
// - Bits 5:4 set third mono output discharge rate or off; reset 00.
// - Bits 3:2 set second stereo pair discharge rate or off; reset 00.
// - Bits 1:0 set first stereo pair discharge rate or off; reset 00.
// - Disabled output tied to mid-supply, low or high resistance by select.
// - Tie-off selects at bits 8 to 11, one per output, reset low.
// - Power register bit 13 forces tie-off buffers on; reset 0.
// - Pending gain change applied after timeout when no zero crossing, while the slow clock runs.
// - Codec interrupt built from four individually maskable events.
// - Status bits 11 to 8 set on both edges of their detectors.
// - Reading the status register clears its bits.
// - Mask bits 11:8 match status bits; 1 masks, 0 passes.
// - Mask bits reset to 0, all sources unmasked.
// - Mic events follow bias current against short and presence thresholds.
module codec_antipop_tieoff_irq_regs
  import codec_ctl_pkg::*;
#(
  parameter int SLOW_DIV = SLOW_DIV_CYCLES
)
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Host register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [15:0]      reg_rdata,
  output logic             reg_rvalid,
  // Output enables and tie-off controls
  input  wire logic [3:0]  output_enable,
  output logic [3:0]       tieoff_active,
  output logic [3:0]       tieoff_high_res,
  output logic             tieoff_buffer_force_on,
  // Pop suppression fields
  output logic [1:0]       ramp_speed,
  output logic [1:0]       mono_b_discharge_rate,
  output logic [1:0]       mono_a_discharge_rate,
  output logic [1:0]       pair_b_discharge_rate,
  output logic [1:0]       pair_a_discharge_rate,
  // Zero-cross timeout
  input  wire logic        slow_clock_enable,
  input  wire logic        zc_enable,
  input  wire logic        gain_pending,
  input  wire logic        zero_cross,
  output logic             gain_update,
  // Detectors
  input  wire logic        jack_left_level,
  input  wire logic        jack_right_level,
  input  wire logic        mic_over_short_threshold,
  input  wire logic        mic_over_present_threshold,
  // Interrupt
  output logic             audio_first_level_irq
);

  logic [3:0]  tieoff_sel_reg;
  logic [3:0]  mask_reg;
  logic [3:0]  mask_next;
  logic [3:0]  status_reg;
  logic [3:0]  status_next;
  logic [3:0]  det_level;
  logic [3:0]  det_prev_reg;
  logic [3:0]  det_event;
  logic [31:0] div_cnt_reg;
  logic        slow_tick_reg;
  logic        wr_pop;
  logic        wr_pwr;
  logic        wr_tieoff;
  logic        wr_mask;
  logic        rd_status;

  assign wr_pop    = reg_wr && (reg_addr == ADDR_POP_SUPPRESS);
  assign wr_pwr    = reg_wr && (reg_addr == ADDR_PWR_MGMT_ONE);
  assign wr_tieoff = reg_wr && (reg_addr == ADDR_TIEOFF_CTRL);
  assign wr_mask   = reg_wr && (reg_addr == ADDR_IRQ_MASK);
  assign rd_status = reg_rd && (reg_addr == ADDR_IRQ_STATUS);

  // ********************************
  // Pop suppression fields
  // ********************************
  // ramp speed field
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ramp_speed <= RATE_RESET;
    end else if (wr_pop) begin
      ramp_speed <= reg_wdata[RAMP_SPEED_LSB +: 2];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mono_b_discharge_rate <= RATE_RESET;
      mono_a_discharge_rate <= RATE_RESET;
      pair_b_discharge_rate <= RATE_RESET;
      pair_a_discharge_rate <= RATE_RESET;
    end else if (wr_pop) begin
      mono_b_discharge_rate <= reg_wdata[MONO_B_DIS_LSB +: 2];
      mono_a_discharge_rate <= reg_wdata[MONO_A_DIS_LSB +: 2];
      pair_b_discharge_rate <= reg_wdata[PAIR_B_DIS_LSB +: 2];
      pair_a_discharge_rate <= reg_wdata[PAIR_A_DIS_LSB +: 2];
    end
  end

  // ********************************
  // Tie-off control
  // ********************************
  // per-output resistance selects
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tieoff_sel_reg <= TIEOFF_SEL_RESET;
    end else if (wr_tieoff) begin
      tieoff_sel_reg <= reg_wdata[TIEOFF_SEL_LSB +: 4];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tieoff_buffer_force_on <= BUF_FORCE_RESET;
    end else if (wr_pwr) begin
      tieoff_buffer_force_on <= reg_wdata[BUF_FORCE_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tieoff_active   <= 4'hf;
      tieoff_high_res <= 4'h0;
    end else begin
      tieoff_active   <= ~output_enable;
      tieoff_high_res <= tieoff_sel_reg & ~output_enable;
    end
  end

  // ********************************
  // Slow clock and zero-cross timeout
  // ********************************
  // ticks only while software runs the slow clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt_reg   <= 32'h0;
      slow_tick_reg <= 1'b0;
    end else if (!slow_clock_enable) begin
      div_cnt_reg   <= 32'h0;
      slow_tick_reg <= 1'b0;
    end else if (div_cnt_reg == 32'(SLOW_DIV - 1)) begin
      div_cnt_reg   <= 32'h0;
      slow_tick_reg <= 1'b1;
    end else begin
      div_cnt_reg   <= div_cnt_reg + 32'h1;
      slow_tick_reg <= 1'b0;
    end
  end

  zero_cross_timeout u_zc (
    .mclk         (mclk),
    .rst          (rst),
    .slow_tick    (slow_tick_reg),
    .zc_enable    (zc_enable),
    .gain_pending (gain_pending),
    .zero_cross   (zero_cross),
    .gain_update  (gain_update)
  );

  // ********************************
  // Codec interrupts
  // ********************************
  // comparator levels per event
  assign det_level = {jack_left_level, jack_right_level,
                      mic_over_short_threshold, mic_over_present_threshold};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      det_prev_reg <= 4'h0;
    end else begin
      det_prev_reg <= det_level;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_evt
      assign det_event[gi]   = det_level[gi] ^ det_prev_reg[gi];
      // Set beats the read clear so no edge is lost
      assign status_next[gi] = det_event[gi] | (status_reg[gi] & ~rd_status);
    end
  endgenerate

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_reg <= IRQ_STAT_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  assign mask_next = wr_mask ? reg_wdata[IRQ_FIELD_LSB +: 4] : mask_reg;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_reg <= IRQ_MASK_RESET;
    end else begin
      mask_reg <= mask_next;
    end
  end

  // unmasked latched bits drive the interrupt
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      audio_first_level_irq <= 1'b0;
    end else begin
      audio_first_level_irq <= |(status_next & ~mask_next);
    end
  end

  // ********************************
  // Read path
  // ********************************
  // Unmapped addresses read zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          ADDR_POP_SUPPRESS:
            reg_rdata <= {6'h00, ramp_speed, mono_b_discharge_rate, mono_a_discharge_rate,
                          pair_b_discharge_rate, pair_a_discharge_rate};
          ADDR_TIEOFF_CTRL:  reg_rdata <= {4'h0, tieoff_sel_reg, 8'h00};
          ADDR_PWR_MGMT_ONE: reg_rdata <= {2'h0, tieoff_buffer_force_on, 13'h0000};
          ADDR_IRQ_STATUS:   reg_rdata <= {4'h0, status_reg, 8'h00};
          ADDR_IRQ_MASK:     reg_rdata <= {4'h0, mask_reg, 8'h00};
          default:           reg_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ********************************
  // Checks
  // ********************************
  sequence s_write(logic [7:0] a);
    reg_wr && (reg_addr == a);
  endsequence

  sequence s_read_status_quiet;
    rd_status && (det_level == det_prev_reg);
  endsequence

  property p_ramp_write;
    @(posedge mclk) disable iff (rst)
      s_write(ADDR_POP_SUPPRESS) |=> ramp_speed == $past(reg_wdata[9:8]);
  endproperty
  a_ramp_write: assert property (p_ramp_write) else $error("ramp speed not written");

  property p_mono_b_write;
    @(posedge mclk) disable iff (rst)
      s_write(ADDR_POP_SUPPRESS) |=> mono_b_discharge_rate == $past(reg_wdata[7:6]);
  endproperty
  a_mono_b_write: assert property (p_mono_b_write) else $error("fourth output rate wrong");

  property p_pair_a_write;
    @(posedge mclk) disable iff (rst)
      s_write(ADDR_POP_SUPPRESS) |=> pair_a_discharge_rate == $past(reg_wdata[1:0]);
  endproperty
  a_pair_a_write: assert property (p_pair_a_write) else $error("first pair rate wrong");

  property p_mono_a_write;
    @(posedge mclk) disable iff (rst)
      s_write(ADDR_POP_SUPPRESS) |=> mono_a_discharge_rate == $past(reg_wdata[MONO_A_DIS_LSB +: 2]);
  endproperty
  a_mono_a_write: assert property (p_mono_a_write) else $error("third output rate wrong");

  property p_pair_b_write;
    @(posedge mclk) disable iff (rst)
      s_write(ADDR_POP_SUPPRESS) |=> pair_b_discharge_rate == $past(reg_wdata[PAIR_B_DIS_LSB +: 2]);
  endproperty
  a_pair_b_write: assert property (p_pair_b_write) else $error("second pair rate wrong");

  property p_tieoff_res;
    @(posedge mclk) disable iff (rst)
      ##1 tieoff_high_res == ($past(tieoff_sel_reg) & ~$past(output_enable));
  endproperty
  a_tieoff_res: assert property (p_tieoff_res) else $error("tie-off resistance wrong");

  property p_tieoff_active;
    @(posedge mclk) disable iff (rst)
      ##1 tieoff_active == ~$past(output_enable);
  endproperty
  a_tieoff_active: assert property (p_tieoff_active) else $error("tie-off not following enables");

  property p_tieoff_sel_write;
    @(posedge mclk) disable iff (rst)
      s_write(ADDR_TIEOFF_CTRL) |=> tieoff_sel_reg == $past(reg_wdata[TIEOFF_SEL_LSB +: 4]);
  endproperty
  a_tieoff_sel_write: assert property (p_tieoff_sel_write) else $error("tie-off selects not written");

  property p_force_on;
    @(posedge mclk) disable iff (rst)
      s_write(ADDR_PWR_MGMT_ONE) |=> tieoff_buffer_force_on == $past(reg_wdata[13]);
  endproperty
  a_force_on: assert property (p_force_on) else $error("buffer force-on not written");

  property p_edge_sets;
    @(posedge mclk) disable iff (rst)
      (jack_left_level != det_prev_reg[3]) |=> status_reg[3] ##1 1'b1;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("jack edge not latched");

  property p_read_clears;
    @(posedge mclk) disable iff (rst)
      s_read_status_quiet |=> (status_reg == 4'h0) && reg_rvalid;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared by read");

  property p_read_set_wins;
    @(posedge mclk) disable iff (rst)
      rd_status |=> status_reg == $past(det_event);
  endproperty
  a_read_set_wins: assert property (p_read_set_wins) else $error("edge lost during status read");

  property p_mask_write;
    @(posedge mclk) disable iff (rst)
      s_write(ADDR_IRQ_MASK) |=> mask_reg == $past(reg_wdata[11:8]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask not written");

  property p_mask_reset;
    @(posedge mclk) $past(rst) && !rst |-> mask_reg == 4'h0;
  endproperty
  a_mask_reset: assert property (p_mask_reset) else $error("mask not clear after reset");

  property p_irq_gate;
    @(posedge mclk) disable iff (rst)
      ##1 audio_first_level_irq == |(status_reg & ~mask_reg);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt does not follow unmasked status");

endmodule : codec_antipop_tieoff_irq_regs

// [design/zero_cross_timeout.sv]
// Zero-cross timeout unit for one gain stage.
// Assumes slow_tick is a one-cycle enable from the slow clock divider.
`timescale 1ns/1ps
module zero_cross_timeout
  import codec_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Slow rate enable
  input  wire logic slow_tick,
  // Gain stage
  input  wire logic zc_enable,
  input  wire logic gain_pending,
  input  wire logic zero_cross,
  output logic      gain_update
);

  zc_state_t  state_reg;
  logic [7:0] tick_reg;

  // ********************************
  // Timeout sequencing
  // ********************************
  // forced gain update
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg   <= ZC_IDLE;
      tick_reg    <= 8'h00;
      gain_update <= 1'b0;
    end else begin
      gain_update <= 1'b0;
      case (state_reg)
        ZC_IDLE: begin
          tick_reg <= 8'h00;
          if (zc_enable && gain_pending) begin
            state_reg <= ZC_WAIT;
          end
        end
        ZC_WAIT: begin
          if (!zc_enable || !gain_pending) begin
            state_reg <= ZC_IDLE;
          end else if (zero_cross) begin
            // Crossing found in time, apply now
            gain_update <= 1'b1;
            state_reg   <= ZC_IDLE;
          end else if (slow_tick) begin
            // Ticks stop with the slow clock, so the wait stretches
            if (tick_reg == ZC_TIMEOUT_TICKS - 8'h01) begin
              gain_update <= 1'b1;
              state_reg   <= ZC_IDLE;
            end else begin
              tick_reg <= tick_reg + 8'h01;
            end
          end
        end
        default: state_reg <= ZC_IDLE;
      endcase
    end
  end

  property p_update_cause;
    @(posedge mclk) disable iff (rst)
      gain_update |-> $past(zc_enable && gain_pending);
  endproperty
  a_update_cause: assert property (p_update_cause) else $error("gain update without pending change");

endmodule : zero_cross_timeout

// [pkg/codec_ctl_pkg.sv]
// Constants, field positions and types shared by the codec control block.
// Assumes a single 50 MHz system clock and a 16-bit register word.
package codec_ctl_pkg;

  // ********************************
  // Register map
  // ********************************
  localparam logic [7:0] ADDR_PWR_MGMT_ONE  = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h1f;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h27;
  localparam logic [7:0] ADDR_TIEOFF_CTRL   = 8'h4c;
  localparam logic [7:0] ADDR_POP_SUPPRESS  = 8'h4e;

  // ********************************
  // Field positions
  // ********************************
  localparam int RAMP_SPEED_LSB   = 8;
  localparam int MONO_B_DIS_LSB   = 6;
  localparam int MONO_A_DIS_LSB   = 4;
  localparam int PAIR_B_DIS_LSB   = 2;
  localparam int PAIR_A_DIS_LSB   = 0;
  localparam int TIEOFF_SEL_LSB   = 8;
  localparam int BUF_FORCE_BIT    = 13;
  localparam int IRQ_FIELD_LSB    = 8;
  localparam int JACK_LEFT_BIT    = 11;
  localparam int JACK_RIGHT_BIT   = 10;
  localparam int MIC_SHORT_BIT    = 9;
  localparam int MIC_PRESENT_BIT  = 8;

  // ********************************
  // Reset values
  // ********************************
  localparam logic [1:0] RATE_RESET       = 2'h0;
  localparam logic [3:0] TIEOFF_SEL_RESET = 4'h0;
  localparam logic       BUF_FORCE_RESET  = 1'b0;
  localparam logic [3:0] IRQ_MASK_RESET   = 4'h0;
  localparam logic [3:0] IRQ_STAT_RESET   = 4'h0;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_PERIOD_NS      = 20;
  localparam int SLOW_PERIOD_US     = 1000;
  localparam int SLOW_DIV_CYCLES    = SLOW_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam logic [7:0] ZC_TIMEOUT_TICKS = 8'h10;

  typedef enum logic [1:0] {
    ZC_IDLE = 2'b01,
    ZC_WAIT = 2'b10
  } zc_state_t;

endpackage : codec_ctl_pkg

// [verification/codec_host_model.sv]
// Host processor model for the codec register port.
// Assumes one-cycle strobes launched just after a rising mclk edge.
`timescale 1ns/1ps
module codec_host_model
  import codec_ctl_pkg::*;
(
  // Clock
  input  wire logic        mclk,
  // Register port
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             reg_wr,
  output logic             reg_rd,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid
);
  // Idle cycles before each access, for a slow host
  int   gap       = 0;
  logic timed_out = 1'b0;

  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    // Released bus shows no stale value
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    int n;
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    n = 0;
    #1;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    timed_out = (reg_rvalid !== 1'b1);
    q = reg_rdata;
  endtask : rd
endmodule : codec_host_model

// [verification/test_codec_antipop_tieoff_irq_regs.sv]
// Self-checking bench for the codec control register bank.
// Assumes the host model drives the register port; slow divider is shrunk.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module test_codec_antipop_tieoff_irq_regs
  import codec_ctl_pkg::*;
;
  localparam int SDIV = 4;
  logic        mclk, rst, reg_wr, reg_rd, reg_rvalid, force_on, slow_clock_enable;
  logic        zc_enable, gain_pending, zero_cross, gain_update, irq;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [3:0]  output_enable, tieoff_active, tieoff_high_res, det;
  logic [1:0]  ramp_speed, mono_b, mono_a, pair_b, pair_a;
  int          check_count = 0;
  int          bad_count   = 0;

  codec_antipop_tieoff_irq_regs #(.SLOW_DIV(SDIV)) codec_antipop_tieoff_irq_regs_i (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .output_enable(output_enable),
    .tieoff_active(tieoff_active), .tieoff_high_res(tieoff_high_res), .tieoff_buffer_force_on(force_on),
    .ramp_speed(ramp_speed), .mono_b_discharge_rate(mono_b), .mono_a_discharge_rate(mono_a),
    .pair_b_discharge_rate(pair_b), .pair_a_discharge_rate(pair_a), .slow_clock_enable(slow_clock_enable),
    .zc_enable(zc_enable), .gain_pending(gain_pending), .zero_cross(zero_cross), .gain_update(gain_update),
    .jack_left_level(det[3]), .jack_right_level(det[2]), .mic_over_short_threshold(det[1]),
    .mic_over_present_threshold(det[0]), .audio_first_level_irq(irq));

  codec_host_model codec_host_model_i (
    .mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial begin
    mclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  end

  // ****************
  // Shared tasks
  // ****************
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e, input string nm);
    logic [15:0] q;
    codec_host_model_i.rd(a, q);
    if (codec_host_model_i.timed_out) begin
      bad_count++;
      results();
    end else begin
      `CHK(nm, e, q)
    end
  endtask : rd_chk

  task automatic wait_upd(input int lim, output int n);
    n = 0;
    #1;
    while (gain_update !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (gain_update !== 1'b1) begin
      bad_count++;
      results();
    end
  endtask : wait_upd

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    rd_chk(ADDR_POP_SUPPRESS, 16'h0000, "pop_reset");
    rd_chk(ADDR_TIEOFF_CTRL, 16'h0000, "tieoff_reset");
    rd_chk(ADDR_PWR_MGMT_ONE, 16'h0000, "pwr_reset");
    rd_chk(ADDR_IRQ_MASK, 16'h0000, "mask_reset");
    `CHK("fields_reset", 10'h000, {ramp_speed, mono_b, mono_a, pair_b, pair_a})
    `CHK("tieoff_reset", 4'hf, tieoff_active)
    codec_host_model_i.wr(ADDR_IRQ_STATUS, 16'hffff);
    rd_chk(ADDR_IRQ_STATUS, 16'h0000, "status_ro");
  endtask : t_reset

  task automatic t_pop;
    logic [1:0]  c;
    logic [15:0] v;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      v = {6'h00, c, c + 2'h1, c + 2'h2, c + 2'h3, c};
      codec_host_model_i.wr(ADDR_POP_SUPPRESS, v | 16'hfc00);
      #1;
      `CHK("ramp_speed", c, ramp_speed)
      `CHK("mono_b", c + 2'h1, mono_b)
      `CHK("mono_a", c + 2'h2, mono_a)
      `CHK("pair_b", c + 2'h3, pair_b)
      `CHK("pair_a", c, pair_a)
      rd_chk(ADDR_POP_SUPPRESS, v, "pop_read");
    end
  endtask : t_pop

  task automatic t_tie;
    logic [3:0] s;
    for (int i = 0; i < 2; i++) begin
      s = (i == 0) ? 4'h5 : 4'ha;
      codec_host_model_i.wr(ADDR_TIEOFF_CTRL, {4'hf, s, 8'hff});
      rd_chk(ADDR_TIEOFF_CTRL, {4'h0, s, 8'h00}, "tieoff_sel");
      for (int j = 0; j < 16; j++) begin
        @(posedge mclk);
        output_enable <= j[3:0];
        repeat (2) @(posedge mclk);
        #1;
        `CHK("tieoff_active", ~j[3:0], tieoff_active)
        `CHK("tieoff_high_res", s & ~j[3:0], tieoff_high_res)
      end
    end
    codec_host_model_i.wr(ADDR_PWR_MGMT_ONE, 16'hffff);
    #1;
    `CHK("force_on", 1'b1, force_on)
    rd_chk(ADDR_PWR_MGMT_ONE, 16'h2000, "pwr_read");
    codec_host_model_i.wr(ADDR_PWR_MGMT_ONE, 16'h0000);
    #1;
    `CHK("force_off", 1'b0, force_on)
    // Unmapped neighbour must not alias the tie-off register
    codec_host_model_i.wr(8'h4d, 16'hffff);
    rd_chk(8'h4d, 16'h0000, "unmapped");
    rd_chk(ADDR_TIEOFF_CTRL, 16'h0a00, "tieoff_kept");
  endtask : t_tie

  task automatic t_irq;
    logic [15:0] bit_v;
    // mic comparators land at bits 9:8
    for (int b = 0; b < 4; b++) begin
      bit_v = 16'h0100 << b;
      @(posedge mclk);
      det[b] <= 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      `CHK("irq_rise", 1'b1, irq)
      rd_chk(ADDR_IRQ_STATUS, bit_v, "status_rise");
      `CHK("irq_cleared", 1'b0, irq)
      codec_host_model_i.wr(ADDR_IRQ_MASK, bit_v);
      @(posedge mclk);
      det[b] <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      `CHK("irq_masked", 1'b0, irq)
      rd_chk(ADDR_IRQ_MASK, bit_v, "mask_read");
      codec_host_model_i.wr(ADDR_IRQ_MASK, 16'h0000);
      #1;
      `CHK("irq_unmask", 1'b1, irq)
      rd_chk(ADDR_IRQ_STATUS, bit_v, "status_fall");
      `CHK("irq_low", 1'b0, irq)
    end
  endtask : t_irq

  task automatic t_zc;
    int n;
    @(posedge mclk);
    slow_clock_enable <= 1'b1;
    zc_enable         <= 1'b1;
    gain_pending      <= 1'b1;
    repeat (2) @(posedge mclk);
    zero_cross <= 1'b1;
    @(posedge mclk);
    zero_cross <= 1'b0;
    wait_upd(4, n);
    `CHK("zc_cross", 0, n)
    @(posedge mclk);
    gain_pending <= 1'b0;
    @(posedge mclk);
    gain_pending <= 1'b1;
    @(posedge mclk);
    wait_upd(300, n);
    `CHK("zc_timeout", 1'b1, n >= (ZC_TIMEOUT_TICKS - 1) * SDIV && n <= (ZC_TIMEOUT_TICKS + 1) * SDIV + 2)
    @(posedge mclk);
    gain_pending <= 1'b0;
  endtask : t_zc

  task automatic t_zc_hold;
    int seen;
    seen = 0;
    @(posedge mclk);
    slow_clock_enable <= 1'b0;
    zc_enable         <= 1'b1;
    gain_pending      <= 1'b1;
    repeat (100) begin
      @(posedge mclk);
      #1;
      if (gain_update !== 1'b0) seen++;
    end
    `CHK("zc_no_slow", 0, seen)
    @(posedge mclk);
    slow_clock_enable <= 1'b1;
    zc_enable         <= 1'b0;
    repeat (100) begin
      @(posedge mclk);
      #1;
      if (gain_update !== 1'b0) seen++;
    end
    `CHK("zc_disabled", 0, seen)
    @(posedge mclk);
    gain_pending <= 1'b0;
  endtask : t_zc_hold

  initial begin
    rst               = 1'b1;
    output_enable     = 4'h0;
    det               = 4'h0;
    slow_clock_enable = 1'b0;
    zc_enable         = 1'b0;
    gain_pending      = 1'b0;
    zero_cross        = 1'b0;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_pop();
    codec_host_model_i.gap = 2;
    t_tie();
    t_irq();
    t_zc();
    t_zc_hold();
    results();
  end
endmodule : test_codec_antipop_tieoff_irq_regs
